/* src/sensor_status_output_regs.sv */
// Operation
// RULE_01: Motion source reports change, sleep, wake, axes.
// RULE_02: Knock source holds any, single, double flags.
// RULE_03: Knock sign bit: zero positive, one negative.
// RULE_04: Knock source holds per-axis X, Y flags.
// RULE_05: Gated ready set when sample taken gated.
// RULE_06: Gated ready latched or pulsed by config.
// RULE_07: New-data flags for temperature and acceleration.
// RULE_08: Temperature is signed 16 bits, low first.
// RULE_09: X and Y are 16 bits, low first.
// RULE_10: Long counter timeout status bit.
// RULE_11: Sixteen state machine bits over two bytes.
// RULE_12: Eight learning core bits in one byte.
// RULE_13: Single write done after first target write.
// RULE_14: Four target no-acknowledge flags.
// RULE_15: Hub transfer done flag reflects completion.
// RULE_16: Unread count is 10 bits over two registers.
// RULE_17: Threshold flag when count reaches threshold level.
// RULE_18: Overrun flag when queue completely filled.
// RULE_19: Full-soon flag predicts full next period.
// RULE_20: Batch hit flag, cleared on limit read.
// RULE_21: Held overrun copy cleared on flags read.
// RULE_22: 32-bit timestamp, 25 us per count.
// RULE_23: Paired hold blocks update until both read.
// RULE_24: Unused bits zero, read-only writes ignored.
`default_nettype none

module sensor_status_output_regs (
  // Clock and reset.
  input wire logic i_mclk,
  input wire logic i_rst_b,
  // Byte register port.
  input wire logic [6:0] i_reg_addr,
  input wire logic i_reg_rd,
  input wire logic i_reg_wr,
  input wire logic [7:0] i_reg_wdata,
  output logic [7:0] o_reg_rdata,
  output logic o_reg_rvalid,
  // Motion and knock detectors.
  input wire logic i_rest_motion_change_flag,
  input wire logic i_sleep_state,
  input wire logic i_motion_event_flag,
  input wire logic i_motion_event_axis_x,
  input wire logic i_motion_event_axis_y,
  input wire logic i_knock_event_flag,
  input wire logic i_knock_single,
  input wire logic i_knock_double,
  input wire logic i_knock_negative,
  input wire logic i_knock_axis_x,
  input wire logic i_knock_axis_y,
  // Samples and gating.
  input wire logic i_temp_valid,
  input wire logic [15:0] i_temp_sample,
  input wire logic i_accel_valid,
  input wire logic [15:0] i_accel_x_sample,
  input wire logic [15:0] i_accel_y_sample,
  input wire logic i_data_gate_input,
  input wire logic i_ready_pulsed,
  input wire logic i_paired_read_hold,
  // Embedded engines and hub.
  input wire logic i_long_counter_timeout_flag,
  input wire logic [15:0] i_state_machine_irq_bit,
  input wire logic [7:0] i_learning_core_irq_bit,
  input wire logic i_single_write_mode,
  input wire logic i_first_target_write_done,
  input wire logic [3:0] i_target_no_ack_flag,
  input wire logic i_hub_transfer_done,
  // Queue status.
  input wire logic [9:0] i_queue_unread_count,
  input wire logic [9:0] i_queue_threshold_level,
  input wire logic i_queue_completely_full,
  input wire logic i_queue_full_soon_flag,
  input wire logic i_batch_count_hit,
  input wire logic i_batch_count_limit_read,
  // Timestamp.
  input wire logic i_time_count_enable,
  // Gated data ready indication.
  output logic o_gated_data_ready
);

  // Selects one byte of a 16-bit pair by the low address bit.
  function automatic logic [7:0] pick_byte(input logic [15:0] word, input logic high);
    pick_byte = high ? word[15:8] : word[7:0];
  endfunction : pick_byte

  logic [7:0] knock_config_q;
  logic [5:0] motion_q;
  logic [5:0] knock_q;
  logic gated_ready_q;
  logic temp_new_q;
  logic accel_new_q;
  logic [15:0] pair_q [sensor_status_pkg::PAIR_COUNT];
  logic [15:0] pend_q [sensor_status_pkg::PAIR_COUNT];
  logic [sensor_status_pkg::PAIR_COUNT-1:0] pend_valid_q;
  logic [sensor_status_pkg::PAIR_COUNT-1:0] read_lo_q;
  logic [sensor_status_pkg::PAIR_COUNT-1:0] read_hi_q;
  logic long_timeout_q;
  logic [15:0] machine_q;
  logic [7:0] learning_q;
  logic write_done_q;
  logic [3:0] no_ack_q;
  logic hub_done_q;
  logic [9:0] unread_q;
  logic threshold_q;
  logic overrun_q;
  logic full_soon_q;
  logic batch_hit_q;
  logic overrun_held_q;
  logic [31:0] time_q;
  logic [9:0] tick_q;

  // Address decode of reads that clear flags or advance the paired hold.
  wire rd_motion = i_reg_rd && (i_reg_addr == sensor_status_pkg::ADDR_MOTION_SRC);
  wire rd_knock = i_reg_rd && (i_reg_addr == sensor_status_pkg::ADDR_KNOCK_SRC);
  wire rd_gated = i_reg_rd && (i_reg_addr == sensor_status_pkg::ADDR_GATED_READY);
  wire rd_temp_hi = i_reg_rd && (i_reg_addr == sensor_status_pkg::ADDR_TEMP_HIGH);
  wire rd_accel_y_hi = i_reg_rd && (i_reg_addr == sensor_status_pkg::ADDR_ACCEL_Y_HIGH);
  wire rd_queue_flags = i_reg_rd && (i_reg_addr == sensor_status_pkg::ADDR_QUEUE_FLAGS);
  wire wr_knock_config = i_reg_wr && (i_reg_addr == sensor_status_pkg::ADDR_KNOCK_CONFIG);
  wire latch_mode = knock_config_q[sensor_status_pkg::KNOCK_CONFIG_LATCH_BIT];
  wire gated_sample = i_accel_valid && i_data_gate_input;
  wire time_tick = i_time_count_enable && (tick_q == sensor_status_pkg::TIME_TICK_LAST);

  // Detector inputs in register bit order; bit 0 and unused bits stay zero.
  // RULE_01 motion source fields
  wire [5:0] motion_in = {i_rest_motion_change_flag, 1'b0, i_sleep_state,
                          i_motion_event_flag, i_motion_event_axis_x, i_motion_event_axis_y};
  // RULE_02 knock kind flags
  // RULE_03 knock sign bit
  // RULE_04 knock axis flags
  wire [5:0] knock_in = {i_knock_event_flag, i_knock_single, i_knock_double,
                         i_knock_negative, i_knock_axis_x, i_knock_axis_y};

  // Per pair: which byte is read now, samples arriving, and the hold state.
  wire [sensor_status_pkg::PAIR_COUNT-1:0] rd_lo = {
    i_reg_rd && (i_reg_addr == sensor_status_pkg::ADDR_ACCEL_Y_LOW),
    i_reg_rd && (i_reg_addr == sensor_status_pkg::ADDR_ACCEL_X_LOW),
    i_reg_rd && (i_reg_addr == sensor_status_pkg::ADDR_TEMP_LOW)};
  wire [sensor_status_pkg::PAIR_COUNT-1:0] rd_hi = {
    rd_accel_y_hi,
    i_reg_rd && (i_reg_addr == sensor_status_pkg::ADDR_ACCEL_X_HIGH),
    rd_temp_hi};
  wire [sensor_status_pkg::PAIR_COUNT-1:0] sample_in = {i_accel_valid, i_accel_valid,
                                                        i_temp_valid};
  wire [sensor_status_pkg::PAIR_COUNT-1:0] read_lo_n = read_lo_q | rd_lo;
  wire [sensor_status_pkg::PAIR_COUNT-1:0] read_hi_n = read_hi_q | rd_hi;
  // RULE_23 hold while half read
  wire [sensor_status_pkg::PAIR_COUNT-1:0] pair_locked =
    {sensor_status_pkg::PAIR_COUNT{i_paired_read_hold}} & (read_lo_n ^ read_hi_n);
  wire [15:0] sample_data [sensor_status_pkg::PAIR_COUNT];
  assign sample_data[sensor_status_pkg::PAIR_TEMP] = i_temp_sample;
  assign sample_data[sensor_status_pkg::PAIR_X] = i_accel_x_sample;
  assign sample_data[sensor_status_pkg::PAIR_Y] = i_accel_y_sample;

  // Read multiplexer; every unmapped address and reserved bit reads zero.
  logic [7:0] read_mux;
  always_comb begin
    read_mux = 8'h00;
    // RULE_24 unused bits zero
    case (i_reg_addr)
      sensor_status_pkg::ADDR_MOTION_SRC: read_mux = {1'b0, motion_q, 1'b0};
      sensor_status_pkg::ADDR_KNOCK_SRC: read_mux = {1'b0, knock_q, 1'b0};
      sensor_status_pkg::ADDR_GATED_READY: read_mux = {gated_ready_q, 7'h00};
      sensor_status_pkg::ADDR_NEW_DATA: read_mux = {5'h00, temp_new_q, 1'b0, accel_new_q};
      // RULE_08 temperature byte order
      sensor_status_pkg::ADDR_TEMP_LOW,
      sensor_status_pkg::ADDR_TEMP_HIGH:
        read_mux = pick_byte(pair_q[sensor_status_pkg::PAIR_TEMP], i_reg_addr[0]);
      // RULE_09 acceleration byte order
      sensor_status_pkg::ADDR_ACCEL_X_LOW,
      sensor_status_pkg::ADDR_ACCEL_X_HIGH:
        read_mux = pick_byte(pair_q[sensor_status_pkg::PAIR_X], i_reg_addr[0]);
      sensor_status_pkg::ADDR_ACCEL_Y_LOW,
      sensor_status_pkg::ADDR_ACCEL_Y_HIGH:
        read_mux = pick_byte(pair_q[sensor_status_pkg::PAIR_Y], i_reg_addr[0]);
      // RULE_10 timeout status bit
      sensor_status_pkg::ADDR_EMBEDDED_STATUS: read_mux = {long_timeout_q, 7'h00};
      // RULE_11 machine status bytes
      sensor_status_pkg::ADDR_MACHINE_LOW: read_mux = machine_q[7:0];
      sensor_status_pkg::ADDR_MACHINE_HIGH: read_mux = machine_q[15:8];
      // RULE_12 learning core byte
      sensor_status_pkg::ADDR_LEARNING: read_mux = learning_q;
      sensor_status_pkg::ADDR_HUB_STATUS: read_mux = {write_done_q, no_ack_q, 2'b00, hub_done_q};
      // RULE_16 unread count split
      sensor_status_pkg::ADDR_QUEUE_FILL_LOW: read_mux = unread_q[7:0];
      sensor_status_pkg::ADDR_QUEUE_FLAGS:
        read_mux = {threshold_q, overrun_q, full_soon_q, batch_hit_q, overrun_held_q,
                    1'b0, unread_q[9:8]};
      // RULE_22 timestamp bytes ascending
      sensor_status_pkg::ADDR_TIME_BYTE0: read_mux = time_q[7:0];
      7'h41: read_mux = time_q[15:8];
      7'h42: read_mux = time_q[23:16];
      sensor_status_pkg::ADDR_TIME_BYTE3: read_mux = time_q[31:24];
      sensor_status_pkg::ADDR_KNOCK_CONFIG: read_mux = knock_config_q;
      default: read_mux = 8'h00;
    endcase
  end

  // Read data is registered, answering one cycle after the strobe.
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_reg_rdata <= 8'h00;
      o_reg_rvalid <= 1'b0;
    end else begin
      o_reg_rvalid <= i_reg_rd;
      o_reg_rdata <= i_reg_rd ? read_mux : 8'h00;
    end
  end

  // Only the configuration register takes writes; reserved bits stay zero.
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      knock_config_q <= sensor_status_pkg::KNOCK_CONFIG_RESET;
    end else if (wr_knock_config) begin
      // RULE_24 reserved bits dropped
      knock_config_q <= i_reg_wdata & sensor_status_pkg::KNOCK_CONFIG_MASK;
    end
  end

  // Event sources follow the detectors, or latch until read in latch mode.
  // The sleep state is a level and is never latched. A new event in the
  // clearing read cycle survives because the set is ORed in last.
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      motion_q <= 6'h00;
      knock_q <= 6'h00;
    end else if (latch_mode) begin
      // RULE_01 latched motion flags
      motion_q <= ((rd_motion ? 6'h00 : motion_q) | motion_in) & 6'h37 | (motion_in & 6'h08);
      // RULE_02 latched knock flags
      knock_q <= (rd_knock ? 6'h00 : knock_q) | knock_in;
    end else begin
      motion_q <= motion_in;
      knock_q <= knock_in;
    end
  end

  // Gated ready: a one-cycle pulse, or held until the register is read.
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      gated_ready_q <= 1'b0;
      o_gated_data_ready <= 1'b0;
    end else begin
      // RULE_05 set on gated sample
      // RULE_06 pulse or latch
      if (i_ready_pulsed) begin
        gated_ready_q <= gated_sample;
        o_gated_data_ready <= gated_sample;
      end else begin
        gated_ready_q <= gated_sample || (gated_ready_q && !rd_gated);
        o_gated_data_ready <= gated_sample || (gated_ready_q && !rd_gated);
      end
    end
  end

  // New-data flags clear on reading the last byte of their output.
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      temp_new_q <= 1'b0;
      accel_new_q <= 1'b0;
    end else begin
      // RULE_07 new data flags
      temp_new_q <= i_temp_valid || (temp_new_q && !rd_temp_hi);
      accel_new_q <= i_accel_valid || (accel_new_q && !rd_accel_y_hi);
    end
  end

  // Output pairs. A sample that arrives while a pair is half read waits in
  // a one-deep pending slot; only the newest waiting sample is kept.
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      for (int k = 0; k < sensor_status_pkg::PAIR_COUNT; k++) begin
        pair_q[k] <= 16'h0000;
        pend_q[k] <= 16'h0000;
      end
      pend_valid_q <= '0;
      read_lo_q <= '0;
      read_hi_q <= '0;
    end else begin
      for (int k = 0; k < sensor_status_pkg::PAIR_COUNT; k++) begin
        // RULE_23 track byte reads
        if (i_paired_read_hold && (read_lo_n[k] ^ read_hi_n[k])) begin
          read_lo_q[k] <= read_lo_n[k];
          read_hi_q[k] <= read_hi_n[k];
        end else begin
          read_lo_q[k] <= 1'b0;
          read_hi_q[k] <= 1'b0;
        end
        // RULE_23 deferred update
        if (pair_locked[k]) begin
          if (sample_in[k]) begin
            pend_q[k] <= sample_data[k];
            pend_valid_q[k] <= 1'b1;
          end
        end else if (sample_in[k]) begin
          pair_q[k] <= sample_data[k];
          pend_valid_q[k] <= 1'b0;
        end else if (pend_valid_q[k]) begin
          pair_q[k] <= pend_q[k];
          pend_valid_q[k] <= 1'b0;
        end
      end
    end
  end

  // Embedded engine and hub status, registered from the engines.
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      long_timeout_q <= 1'b0;
      machine_q <= 16'h0000;
      learning_q <= 8'h00;
      write_done_q <= 1'b0;
      no_ack_q <= 4'h0;
      hub_done_q <= 1'b0;
    end else begin
      long_timeout_q <= i_long_counter_timeout_flag;
      machine_q <= i_state_machine_irq_bit;
      learning_q <= i_learning_core_irq_bit;
      // RULE_13 single write done
      write_done_q <= i_single_write_mode && i_first_target_write_done;
      // RULE_14 per-target no acknowledge
      no_ack_q <= i_target_no_ack_flag;
      // RULE_15 hub completion flag
      hub_done_q <= i_hub_transfer_done;
    end
  end

  // Queue status. Batch hit and held overrun are sticky; set beats clear.
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      unread_q <= 10'h000;
      threshold_q <= 1'b0;
      overrun_q <= 1'b0;
      full_soon_q <= 1'b0;
      batch_hit_q <= 1'b0;
      overrun_held_q <= 1'b0;
    end else begin
      unread_q <= i_queue_unread_count;
      // RULE_17 threshold compare
      threshold_q <= (i_queue_unread_count >= i_queue_threshold_level);
      // RULE_18 overrun level
      overrun_q <= i_queue_completely_full;
      // RULE_19 predictive full
      full_soon_q <= i_queue_full_soon_flag;
      // RULE_20 batch hit sticky
      batch_hit_q <= i_batch_count_hit || (batch_hit_q && !i_batch_count_limit_read);
      // RULE_21 held overrun
      overrun_held_q <= i_queue_completely_full || (overrun_held_q && !rd_queue_flags);
    end
  end

  // Timestamp divider and counter; disabling the counter freezes it.
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      tick_q <= 10'h000;
      time_q <= 32'h0000_0000;
    end else if (i_time_count_enable) begin
      // RULE_22 one count per tick
      tick_q <= time_tick ? 10'h000 : tick_q + 10'h001;
      if (time_tick) begin
        time_q <= time_q + 32'h0000_0001;
      end
    end
  end

  // Checks next to the logic they guard.
  AST_KNOCK_SIGN: assert property (@(posedge i_mclk) disable iff (!i_rst_b) // RULE_03
    !latch_mode |=> knock_q[sensor_status_pkg::KNOCK_SIGN_BIT-1] == $past(i_knock_negative))
    else $error("Knock sign does not follow detector.");

  AST_MOTION_LATCH: assert property (@(posedge i_mclk) disable iff (!i_rst_b) // RULE_01
    latch_mode && !rd_motion && motion_q[sensor_status_pkg::MOTION_ANY_BIT-1] && !wr_knock_config
    |=> motion_q[sensor_status_pkg::MOTION_ANY_BIT-1])
    else $error("Latched motion flag dropped without read.");

  AST_GATED_PULSE: assert property (@(posedge i_mclk) disable iff (!i_rst_b) // RULE_06
    i_ready_pulsed && gated_sample ##1 i_ready_pulsed && !gated_sample |=> !gated_ready_q)
    else $error("Pulsed gated ready lasted more than one cycle.");

  AST_TEMP_NEW: assert property (@(posedge i_mclk) disable iff (!i_rst_b) // RULE_07
    i_temp_valid |=> temp_new_q ##1 (temp_new_q || $past(rd_temp_hi)))
    else $error("Temperature new flag lost.");

  AST_THRESHOLD: assert property (@(posedge i_mclk) disable iff (!i_rst_b) // RULE_17
    $past(i_rst_b) |->
    threshold_q == ($past(i_queue_unread_count) >= $past(i_queue_threshold_level)))
    else $error("Threshold flag wrong.");

  AST_HELD_OVERRUN: assert property (@(posedge i_mclk) disable iff (!i_rst_b) // RULE_21
    i_queue_completely_full |=> overrun_held_q && overrun_q)
    else $error("Overrun not held.");

  AST_BATCH_CLEAR: assert property (@(posedge i_mclk) disable iff (!i_rst_b) // RULE_20
    i_batch_count_limit_read && !i_batch_count_hit |=> !batch_hit_q)
    else $error("Batch flag not cleared on limit read.");

  AST_PAIR_HOLD: assert property (@(posedge i_mclk) disable iff (!i_rst_b) // RULE_23
    pair_locked[sensor_status_pkg::PAIR_X] |=> $stable(pair_q[sensor_status_pkg::PAIR_X]))
    else $error("Half-read pair updated.");

  AST_TIME_STEP: assert property (@(posedge i_mclk) disable iff (!i_rst_b) // RULE_22
    time_tick |=> time_q == $past(time_q) + 32'h0000_0001)
    else $error("Timestamp did not advance on tick.");

  AST_WRITE_DONE: assert property (@(posedge i_mclk) disable iff (!i_rst_b) // RULE_13
    !i_single_write_mode |=> !write_done_q)
    else $error("Write done set outside single write mode.");

  AST_READ_ANSWER: assert property (@(posedge i_mclk) disable iff (!i_rst_b) // RULE_24
    i_reg_rd && (i_reg_addr == sensor_status_pkg::ADDR_GATED_READY)
    |=> o_reg_rvalid && (o_reg_rdata[6:0] == 7'h00))
    else $error("Reserved bits not zero.");

endmodule : sensor_status_output_regs

`default_nettype wire

/* src/sensor_status_pkg.sv */
`default_nettype none

package sensor_status_pkg;

  // Register offsets on the byte register port.
  localparam logic [6:0] ADDR_MOTION_SRC = 7'h1b;
  localparam logic [6:0] ADDR_KNOCK_SRC = 7'h1c;
  localparam logic [6:0] ADDR_GATED_READY = 7'h1d;
  localparam logic [6:0] ADDR_NEW_DATA = 7'h1e;
  localparam logic [6:0] ADDR_TEMP_LOW = 7'h20;
  localparam logic [6:0] ADDR_TEMP_HIGH = 7'h21;
  localparam logic [6:0] ADDR_ACCEL_X_LOW = 7'h28;
  localparam logic [6:0] ADDR_ACCEL_X_HIGH = 7'h29;
  localparam logic [6:0] ADDR_ACCEL_Y_LOW = 7'h2a;
  localparam logic [6:0] ADDR_ACCEL_Y_HIGH = 7'h2b;
  localparam logic [6:0] ADDR_EMBEDDED_STATUS = 7'h35;
  localparam logic [6:0] ADDR_MACHINE_LOW = 7'h36;
  localparam logic [6:0] ADDR_MACHINE_HIGH = 7'h37;
  localparam logic [6:0] ADDR_LEARNING = 7'h38;
  localparam logic [6:0] ADDR_HUB_STATUS = 7'h39;
  localparam logic [6:0] ADDR_QUEUE_FILL_LOW = 7'h3a;
  localparam logic [6:0] ADDR_QUEUE_FLAGS = 7'h3b;
  localparam logic [6:0] ADDR_TIME_BYTE0 = 7'h40;
  localparam logic [6:0] ADDR_TIME_BYTE3 = 7'h43;
  localparam logic [6:0] ADDR_KNOCK_CONFIG = 7'h56;

  // Writable bits of the knock filter configuration; bits 7 and 1 are reserved.
  localparam logic [7:0] KNOCK_CONFIG_MASK = 8'h7d;
  localparam logic [7:0] KNOCK_CONFIG_RESET = 8'h00;
  localparam int KNOCK_CONFIG_LATCH_BIT = 0;

  // Field positions in the event source registers.
  localparam int MOTION_CHANGE_BIT = 6;
  localparam int MOTION_SLEEP_BIT = 4;
  localparam int MOTION_ANY_BIT = 3;
  localparam int KNOCK_ANY_BIT = 6;
  localparam int KNOCK_SIGN_BIT = 3;
  localparam int NEW_TEMP_BIT = 2;
  localparam int NEW_ACCEL_BIT = 0;
  localparam int GATED_READY_BIT = 7;

  // Output pairs: temperature, X, Y.
  localparam int PAIR_COUNT = 3;
  localparam int PAIR_TEMP = 0;
  localparam int PAIR_X = 1;
  localparam int PAIR_Y = 2;

  // Timestamp tick.
  localparam int CLOCK_PERIOD_NS = 40;
  localparam int TIME_LSB_NS = 25000;
  localparam int TIME_TICK_CYCLES = TIME_LSB_NS / CLOCK_PERIOD_NS;
  localparam logic [9:0] TIME_TICK_LAST = 10'(TIME_TICK_CYCLES - 1);

endpackage : sensor_status_pkg

`default_nettype wire

/* verif/host_port_model.sv */
`default_nettype none

// Host that reads and writes the byte register port from the far side.
module host_port_model (
  // Clock.
  input wire logic i_mclk,
  // Answers from the register bank.
  input wire logic [7:0] i_rdata,
  input wire logic i_rvalid,
  // Requests to the register bank.
  output logic [6:0] o_addr,
  output logic o_rd,
  output logic o_wr,
  output logic [7:0] o_wdata
);
  timeunit 1ns;
  timeprecision 1ps;

  // Idle bus at time zero.
  initial begin
    o_addr = 7'h00;
    o_rd = 1'h0;
    o_wr = 1'h0;
    o_wdata = 8'h00;
  end

  // One byte read; the answer is taken at the edge where valid is seen, bounded wait.
  task automatic read_byte(input logic [6:0] a, output logic [7:0] d);
    int n;
    n = 0;
    o_addr <= a;
    o_rd <= 1'h1;
    @(posedge i_mclk);
    o_rd <= 1'h0;
    do begin
      @(posedge i_mclk);
      n++;
    end while (!i_rvalid && n < 4);
    d = i_rdata;
  endtask : read_byte

  // One byte write; data is scrambled once released so a stale value never helps.
  task automatic write_byte(input logic [6:0] a, input logic [7:0] d);
    o_addr <= a;
    o_wdata <= d;
    o_wr <= 1'h1;
    @(posedge i_mclk);
    o_wr <= 1'h0;
    o_wdata <= ~d;
    @(posedge i_mclk);
  endtask : write_byte
endmodule : host_port_model

`default_nettype wire

/* verif/tb_sensor_status_output_regs.sv */
`default_nettype none

module tb_sensor_status_output_regs;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = '0;
  logic rst_b = '0;
  logic [6:0] addr;
  logic rd, wr, rvalid, gdr;
  logic [7:0] wdata, rdata, m_cfg = '0;
  logic [4:0] mot = '0, m_mot = '0;
  logic [5:0] knk = '0;
  logic [15:0] fsm = '0, ts = '0, xs = '0, ys = '0;
  logic [7:0] learning_core = '0;
  logic [3:0] nack = '0;
  logic [9:0] cnt = '0, queue_threshold_level = '0;
  logic lct = '0, wmode = '0, wdone = '0, hubd = '0, qfull = '0, qsoon = '0, bhit = '0;
  logic blim = '0, tv = '0, av = '0, gate = '0, pulsed = '0, hold = '0, ten = '0;
  logic m_gr = '0, m_tnew = '0, m_anew = '0, m_held = '0, m_batch = '0;
  int m_t, m_x, m_y, m_time, nx;
  int errors = 0;
  int num_checks = 0;

  // Free-running 25 MHz clock.
  always #20 mclk = ~mclk;

  sensor_status_output_regs u_dut (
    .i_mclk(mclk), .i_rst_b(rst_b), .i_reg_addr(addr), .i_reg_rd(rd), .i_reg_wr(wr),
    .i_reg_wdata(wdata), .o_reg_rdata(rdata), .o_reg_rvalid(rvalid),
    .i_rest_motion_change_flag(mot[4]), .i_sleep_state(mot[3]), .i_motion_event_flag(mot[2]),
    .i_motion_event_axis_x(mot[1]), .i_motion_event_axis_y(mot[0]),
    .i_knock_event_flag(knk[5]), .i_knock_single(knk[4]), .i_knock_double(knk[3]),
    .i_knock_negative(knk[2]), .i_knock_axis_x(knk[1]), .i_knock_axis_y(knk[0]),
    .i_temp_valid(tv), .i_temp_sample(ts), .i_accel_valid(av), .i_accel_x_sample(xs),
    .i_accel_y_sample(ys), .i_data_gate_input(gate), .i_ready_pulsed(pulsed),
    .i_paired_read_hold(hold), .i_long_counter_timeout_flag(lct), .i_state_machine_irq_bit(fsm),
    .i_learning_core_irq_bit(learning_core), .i_single_write_mode(wmode), .i_first_target_write_done(wdone),
    .i_target_no_ack_flag(nack), .i_hub_transfer_done(hubd), .i_queue_unread_count(cnt),
    .i_queue_threshold_level(queue_threshold_level), .i_queue_completely_full(qfull), .i_queue_full_soon_flag(qsoon),
    .i_batch_count_hit(bhit), .i_batch_count_limit_read(blim), .i_time_count_enable(ten),
    .o_gated_data_ready(gdr));

  host_port_model u_host (.i_mclk(mclk), .i_rdata(rdata), .i_rvalid(rvalid), .o_addr(addr),
    .o_rd(rd), .o_wr(wr), .o_wdata(wdata));

  // Expected register contents from the model state and the current input levels.
  function automatic logic [7:0] exp_of(input logic [6:0] a);
    case (a)
      7'h1b: return {1'h0, m_mot[4], 1'h0, m_mot[3:0], 1'h0};
      7'h1c: return {1'h0, knk, 1'h0};
      7'h1d: return {m_gr, 7'h00};
      7'h1e: return {5'h00, m_tnew, 1'h0, m_anew};
      7'h20: return m_t[7:0];
      7'h21: return m_t[15:8];
      7'h28: return m_x[7:0];
      7'h29: return m_x[15:8];
      7'h2a: return m_y[7:0];
      7'h2b: return m_y[15:8];
      7'h35: return {lct, 7'h00};
      7'h36: return fsm[7:0];
      7'h37: return fsm[15:8];
      7'h38: return learning_core;
      7'h39: return {wmode & wdone, nack, 2'h0, hubd};
      7'h3a: return cnt[7:0];
      7'h3b: return {cnt >= queue_threshold_level, qfull, qsoon, m_batch, m_held, 1'h0, cnt[9:8]};
      7'h40, 7'h41, 7'h42, 7'h43: return 8'(m_time >> (8 * (a - 7'h40)));
      7'h56: return m_cfg;
      default: return 8'h00;
    endcase
  endfunction : exp_of

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : end_of_test

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input logic [6:0] a);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("BAD %0t addr %h got %h exp %h", $time, a, got, exp);
    end
  endtask : chk8

  task automatic chk1(input logic got, input logic exp);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("BAD %0t gated ready got %b exp %b", $time, got, exp);
    end
  endtask : chk1

  // Reads one byte, compares it, then applies the clear-on-read effects to the model.
  task automatic rd_chk(input logic [6:0] a);
    logic [7:0] d;
    logic [7:0] e;
    e = exp_of(a);
    u_host.read_byte(a, d);
    chk8(d, e, a);
    if (a == 7'h3b) m_held = qfull;
    if (a == 7'h21) m_tnew = 1'h0;
    if (a == 7'h2b) m_anew = 1'h0;
    if (a == 7'h1d && !pulsed) m_gr = 1'h0;
  endtask : rd_chk

  // A hang costs one mismatch; the run is about 2200 cycles long.
  initial begin
    repeat (20000) @(posedge mclk);
    errors++;
    end_of_test();
  end

  initial begin
    logic [6:0] all_a [24] = '{7'h1b, 7'h1c, 7'h1d, 7'h1e, 7'h20, 7'h21, 7'h28, 7'h29, 7'h2a,
      7'h2b, 7'h35, 7'h36, 7'h37, 7'h38, 7'h39, 7'h3a, 7'h3b, 7'h40, 7'h41, 7'h42, 7'h43,
      7'h56, 7'h00, 7'h7f};
    void'($urandom(32'he2a8));
    repeat (12) @(posedge mclk);
    rst_b <= 1'h1;
    @(posedge mclk);
    // Quiet inputs after reset: every mapped place and two unmapped ones read their model values.
    foreach (all_a[i])
      rd_chk(all_a[i]);
    u_host.write_byte(7'h56, 8'hff);
    u_host.write_byte(7'h1e, 8'hff);
    m_cfg = 8'hff & sensor_status_pkg::KNOCK_CONFIG_MASK;
    rd_chk(7'h56);
    rd_chk(7'h1e);
    mot <= 5'h1f;
    @(posedge mclk);
    mot <= 5'h00;
    m_mot = 5'h17;
    repeat (2) @(posedge mclk);
    rd_chk(7'h1b);
    u_host.write_byte(7'h56, 8'h00);
    m_cfg = 8'h00;
    // Random levels; the threshold sits one below, at or one above the count.
    repeat (8) begin
      {mot, knk, fsm, learning_core, lct, wmode, wdone, nack, hubd} <= 43'({$urandom, $urandom});
      {qfull, qsoon, bhit} <= 3'($urandom);
      nx = $urandom;
      cnt <= 10'(nx);
      queue_threshold_level <= 10'(nx + $urandom_range(2) - 1);
      repeat (2) @(posedge mclk);
      m_mot = mot;
      m_held |= qfull;
      m_batch |= bhit;
      rd_chk(7'h1b);
      rd_chk(7'h1c);
      rd_chk(7'h35);
      rd_chk(7'h36);
      rd_chk(7'h37);
      rd_chk(7'h38);
      rd_chk(7'h39);
      rd_chk(7'h3a);
      rd_chk(7'h3b);
      rd_chk(7'h3b);
    end
    bhit <= 1'h0;
    @(posedge mclk);
    blim <= 1'h1;
    @(posedge mclk);
    blim <= 1'h0;
    m_batch = 1'h0;
    repeat (2) @(posedge mclk);
    rd_chk(7'h3b);
    // Gated samples on all pairs with the ready indication latched.
    gate <= 1'h1;
    tv <= 1'h1;
    av <= 1'h1;
    {ts, xs, ys} <= 48'({$urandom, $urandom});
    @(posedge mclk);
    tv <= 1'h0;
    av <= 1'h0;
    m_t = ts;
    m_x = xs;
    m_y = ys;
    {m_gr, m_tnew, m_anew} = 3'h7;
    repeat (2) @(posedge mclk);
    chk1(gdr, 1'h1);
    rd_chk(7'h1e);
    rd_chk(7'h1d);
    @(posedge mclk);
    chk1(gdr, 1'h0);
    for (int i = 4; i < 10; i++)
      rd_chk(all_a[i]);
    rd_chk(7'h1e);
    // Pulsed mode: the indication lasts exactly one cycle.
    pulsed <= 1'h1;
    @(posedge mclk);
    av <= 1'h1;
    @(posedge mclk);
    av <= 1'h0;
    @(posedge mclk);
    chk1(gdr, 1'h1);
    @(posedge mclk);
    chk1(gdr, 1'h0);
    // Paired hold, with an ungated sample that must not raise the ready.
    hold <= 1'h1;
    gate <= 1'h0;
    @(posedge mclk);
    rd_chk(7'h28);
    xs <= 16'($urandom);
    av <= 1'h1;
    @(posedge mclk);
    av <= 1'h0;
    nx = xs;
    repeat (2) @(posedge mclk);
    chk1(gdr, 1'h0);
    rd_chk(7'h28);
    rd_chk(7'h29);
    m_x = nx;
    rd_chk(7'h28);
    rd_chk(7'h29);
    // Timestamp runs three ticks and some, then stops.
    ten <= 1'h1;
    repeat (3 * sensor_status_pkg::TIME_TICK_CYCLES + 25) @(posedge mclk);
    ten <= 1'h0;
    m_time = 3;
    repeat (2) @(posedge mclk);
    for (int i = 17; i < 21; i++)
      rd_chk(all_a[i]);
    end_of_test();
  end
endmodule : tb_sensor_status_output_regs

`default_nettype wire
